//--- verilog/rcc_ctrl.sv
// Reclocker output configuration control: straps, overrides, auto output settings, status pin
`timescale 1ns/1ns
`default_nettype none
`include "rcc_consts.svh"
module rcc_ctrl
  import rcc_pkg::*;
#(
  parameter int AMP_W = 8,
  parameter int EDGE_W = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] path_strap,
  input wire logic [1:0] equalizer_strap,
  input wire logic [1:0] line_amplitude_strap,
  input wire logic cdr_lock,
  input wire logic [3:0] cdr_rate_code,
  input wire logic cdr_frac_rate,
  input wire logic signal_present,
  input wire logic eye_sample_hit,
  input wire logic path_ovr_en,
  input wire logic path_ovr_reclock,
  input wire logic amp_ovr_en,
  input wire logic [1:0] amp_ovr_level,
  input wire logic [AMP_W-1:0] amp_nominal,
  input wire logic preemph_auto_dis,
  input wire logic preemph_force,
  input wire logic [3:0] preemph_amount,
  input wire logic edge_ovr_en,
  input wire logic [EDGE_W-1:0] edge_ovr_value,
  input wire logic invert_line_a,
  input wire logic invert_line_b,
  input wire logic invert_loopback,
  input wire logic lb_ovr_amp_en,
  input wire logic [7:0] lb_ovr_amp,
  input wire logic lb_ovr_deemph_en,
  input wire logic [3:0] lb_ovr_deemph,
  input wire logic [1:0] status_sel,
  input wire logic int_event,
  input wire logic int_status_read,
  input wire logic eye_start,
  output logic reclock_en,
  output logic eq_enable,
  output logic fixed_eq_mode,
  output logic adaptive_eq_mode,
  output logic [7:0] eq_fixed_boost,
  output logic [AMP_W-1:0] line_amp,
  output logic preemph_en,
  output logic [3:0] preemph_level,
  output logic [EDGE_W-1:0] edge_rate,
  output logic pol_line_output_a,
  output logic pol_line_output_b,
  output logic pol_host_loopback_output,
  output logic [7:0] lb_amp,
  output logic [3:0] lb_deemph,
  output logic [6:0] rate_class,
  output logic eye_monitor_en,
  output logic [5:0] eye_phase,
  output logic [5:0] eye_volt,
  output logic eye_busy,
  output logic eye_done,
  output logic [6:0] horizontal_eye_width,
  output logic [6:0] vertical_eye_height,
  output logic status_pin_out,
  output logic status_pin_oe
);
  typedef struct packed {
    logic [1:0] s1_path, s2_path, s1_eq, s2_eq, s1_amp, s2_amp;
    logic [1:0] path_lv, eq_lv, amp_lv;
    logic [1:0] strap_cnt;
    logic lk1, lk2, sd1, sd2, ev1, ev2;
    logic [3:0] rc1, rc2;
    rcc_rate_t rate;
    logic reclock, fixed_eq, adapt_eq;
    logic [7:0] eq_boost;
    logic [AMP_W-1:0] amp;
    logic pe_auto, pe;
    logic [3:0] pe_lvl;
    logic [EDGE_W-1:0] edge_auto, edge_out;
    logic pa, pb, pl;
    logic [7:0] lba;
    logic [3:0] lbd;
    logic int_flag;
    logic st_oe;
    logic eye_en;
  } rcc_state_t;
  rcc_state_t q, next_q;
  logic straps_ready;
  logic eye_en_c;
  rcc_rate_t dec_rate;
  logic rate_ok;
  default clocking cb_ast @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Rate code from the recovery loop; the fractional flag does not alter the class
  function automatic rcc_rate_t rate_decode(input logic [3:0] code);
    case (code)
      4'h1: rate_decode = RCC_RATE_12G;
      4'h2: rate_decode = RCC_RATE_6G;
      4'h3: rate_decode = RCC_RATE_3G;
      4'h4: rate_decode = RCC_RATE_1G5;
      4'h5: rate_decode = RCC_RATE_SD;
      4'h6: rate_decode = RCC_RATE_MADI;
      default: rate_decode = RCC_RATE_NONE;
    endcase
  endfunction
  function automatic logic [AMP_W-1:0] amp_scale(input logic [1:0] lvl, input logic [AMP_W-1:0] nom);
    case (lvl)
      `RCC_LVL_H: amp_scale = nom + AMP_W'(`RCC_AMP_STEP_5);
      `RCC_LVL_R: amp_scale = nom + AMP_W'(`RCC_AMP_STEP_10);
      `RCC_LVL_L: amp_scale = nom - AMP_W'(`RCC_AMP_STEP_5);
      default: amp_scale = nom;
    endcase
  endfunction
  always_comb begin
    next_q = q;
    straps_ready = (q.strap_cnt == 2'h3);
    dec_rate = rate_decode(q.rc2);
    rate_ok = (dec_rate != RCC_RATE_NONE);
    // Pin inputs through two flops
    next_q.s1_path = path_strap;
    next_q.s2_path = q.s1_path;
    next_q.s1_eq = equalizer_strap;
    next_q.s2_eq = q.s1_eq;
    next_q.s1_amp = line_amplitude_strap;
    next_q.s2_amp = q.s1_amp;
    next_q.lk1 = cdr_lock;
    next_q.lk2 = q.lk1;
    next_q.sd1 = signal_present;
    next_q.sd2 = q.sd1;
    next_q.ev1 = int_event;
    next_q.ev2 = q.ev1;
    next_q.rc1 = cdr_rate_code;
    next_q.rc2 = q.rc1;
    // Straps captured once, after the synchroniser has settled
    if (q.strap_cnt == 2'h2) begin
      next_q.path_lv = q.s2_path;
      next_q.eq_lv = q.s2_eq;
      next_q.amp_lv = q.s2_amp;
    end
    if (!straps_ready) next_q.strap_cnt = q.strap_cnt + 2'h1;
    // Path decision
    if (path_ovr_en) begin
      next_q.reclock = path_ovr_reclock;
    end else begin
      next_q.reclock = (q.path_lv == `RCC_LVL_H) || (q.path_lv == `RCC_LVL_F);
    end
    // 125M class never reclocks; forced first so the equalizer mode follows the real bypass
    if (q.rate == RCC_RATE_MADI) next_q.reclock = 1'b0;
    // Equalizer mode; the equalizer itself is never switched off
    if (!next_q.reclock || q.eq_lv != `RCC_LVL_F) begin
      next_q.fixed_eq = 1'b1;
      next_q.adapt_eq = 1'b0;
    end else begin
      // Adaptive unless the class is 1G5 or SD (so adaptive also with no class yet) in normal strap setting
      next_q.adapt_eq = !(q.rate == RCC_RATE_1G5 || q.rate == RCC_RATE_SD);
      next_q.fixed_eq = !next_q.adapt_eq;
    end
    case (q.eq_lv)
      `RCC_LVL_R: next_q.eq_boost = `RCC_EQ_FIXED_R;
      `RCC_LVL_L: next_q.eq_boost = `RCC_EQ_FIXED_L;
      default: next_q.eq_boost = `RCC_EQ_FIXED_ZERO;
    endcase
    // Rate class tracking, only on lock with a changed class
    if (q.lk2 && rate_ok && dec_rate != q.rate) begin
      next_q.rate = dec_rate;
      next_q.pe_auto = (dec_rate == RCC_RATE_12G) || (dec_rate == RCC_RATE_6G);
      case (dec_rate)
        RCC_RATE_12G: next_q.edge_auto = EDGE_W'(`RCC_EDGE_12G);
        RCC_RATE_6G: next_q.edge_auto = EDGE_W'(`RCC_EDGE_6G);
        RCC_RATE_3G: next_q.edge_auto = EDGE_W'(`RCC_EDGE_3G);
        RCC_RATE_1G5: next_q.edge_auto = EDGE_W'(`RCC_EDGE_1G5);
        default: next_q.edge_auto = EDGE_W'(`RCC_EDGE_SD);
      endcase
    end
    next_q.eye_en = q.lk2 && (q.rate == RCC_RATE_12G || q.rate == RCC_RATE_6G || q.rate == RCC_RATE_3G);
    next_q.amp = amp_scale(amp_ovr_en ? amp_ovr_level : q.amp_lv, amp_nominal);
    if (!q.reclock || preemph_auto_dis) begin
      next_q.pe = preemph_force;
    end else begin
      next_q.pe = q.pe_auto;
    end
    next_q.pe_lvl = preemph_amount;
    // Bypassed: no automatic edge rate, host value applies
    next_q.edge_out = (!q.reclock || edge_ovr_en) ? edge_ovr_value : q.edge_auto;
    next_q.pa = invert_line_a;
    next_q.pb = invert_line_b;
    next_q.pl = invert_loopback;
    next_q.lba = lb_ovr_amp_en ? lb_ovr_amp : `RCC_LB_AMP_RST;
    next_q.lbd = lb_ovr_deemph_en ? lb_ovr_deemph : `RCC_LB_DEEMPH_RST;
    // Sticky interrupt: a new event wins over the read clear
    if (q.ev2) next_q.int_flag = 1'b1;
    else if (int_status_read) next_q.int_flag = 1'b0;
    // Enable low pulls the pin low
    case (status_sel)
      `RCC_STAT_SIGDET: next_q.st_oe = !q.sd2;
      `RCC_STAT_INT: next_q.st_oe = !(q.int_flag || q.ev2);
      default: next_q.st_oe = !(q.lk2 && rate_ok);
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{rate: RCC_RATE_NONE, amp: AMP_W'(`RCC_AMP_NOM), lba: `RCC_LB_AMP_RST,
             lbd: `RCC_LB_DEEMPH_RST, edge_auto: EDGE_W'(`RCC_EDGE_SD), edge_out: EDGE_W'(`RCC_EDGE_SD),
             path_lv: `RCC_LVL_F, eq_lv: `RCC_LVL_F, amp_lv: `RCC_LVL_F, reclock: 1'b1,
             fixed_eq: 1'b1, st_oe: 1'b1, default: '0};
    end else begin
      q <= next_q;
    end
  end
  // Eye monitor allowed only at 3G class or faster
  assign eye_en_c = q.eye_en;
  rcc_eye_scan #(
    .STEPS(64)
  ) u_eye (
    .clk(clk),
    .rst_n(rst_n),
    .enable(eye_en_c),
    .start(eye_start),
    .sample_hit(eye_sample_hit),
    .phase_idx(eye_phase),
    .volt_idx(eye_volt),
    .busy(eye_busy),
    .done(eye_done),
    .eye_width(horizontal_eye_width),
    .eye_height(vertical_eye_height)
  );
  assign reclock_en = q.reclock;
  assign eq_enable = 1'b1;
  assign fixed_eq_mode = q.fixed_eq;
  assign adaptive_eq_mode = q.adapt_eq;
  assign eq_fixed_boost = q.eq_boost;
  assign line_amp = q.amp;
  assign preemph_en = q.pe;
  assign preemph_level = q.pe_lvl;
  assign edge_rate = q.edge_out;
  assign pol_line_output_a = q.pa;
  assign pol_line_output_b = q.pb;
  assign pol_host_loopback_output = q.pl;
  assign lb_amp = q.lba;
  assign lb_deemph = q.lbd;
  assign rate_class = q.rate;
  assign eye_monitor_en = eye_en_c;
  assign status_pin_out = 1'b0;
  assign status_pin_oe = q.st_oe;
  AST_MADI_BYPASS: assert property (
    rate_class == 7'h40 |=> !reclock_en)
    else $error("125M rate not bypassed");
  AST_RATE_CLASS: assert property (
    q.lk2 && rate_ok |=> rate_class == $past(dec_rate))
    else $error("Locked rate class not taken");
  AST_EYE_GATE: assert property (
    !q.lk2 || rate_class[3:1] == 3'h0 |=> !eye_monitor_en)
    else $error("Eye monitor enabled below 3G");
  AST_PATH_STRAP: assert property (
    !path_ovr_en && straps_ready && q.rate != RCC_RATE_MADI && q.path_lv[1] |=> reclock_en)
    else $error("H or F path strap did not reclock");
  AST_BYPASS_FIXED: assert property (
    !reclock_en |-> fixed_eq_mode && !adaptive_eq_mode)
    else $error("Bypass not in fixed equalizer mode");
  AST_EQ_BOOST_L: assert property (
    q.eq_lv == `RCC_LVL_L |=> eq_fixed_boost == `RCC_EQ_FIXED_L)
    else $error("Equalizer strap L boost wrong");
  AST_PATH_OVR: assert property (
    path_ovr_en && q.rate != RCC_RATE_MADI |=> reclock_en == $past(path_ovr_reclock))
    else $error("Path override ignored");
  AST_EQ_ON: assert property (
    eq_enable)
    else $error("Equalizer off");
  AST_AMP_STRAP_H: assert property (
    !amp_ovr_en && q.amp_lv == `RCC_LVL_H |=> line_amp == $past(amp_nominal) + AMP_W'(`RCC_AMP_STEP_5))
    else $error("Amplitude strap H wrong");
  AST_AMP_OVR_L: assert property (
    amp_ovr_en && amp_ovr_level == `RCC_LVL_L |=> line_amp == $past(amp_nominal) - AMP_W'(`RCC_AMP_STEP_5))
    else $error("Amplitude override L wrong");
  AST_PE_AUTO: assert property (
    reclock_en && !preemph_auto_dis |=> preemph_en == $past(q.pe_auto))
    else $error("Auto pre-emphasis wrong");
  AST_PE_FORCE: assert property (
    !reclock_en |=> preemph_en == $past(preemph_force))
    else $error("Manual pre-emphasis ignored");
  AST_PE_LEVEL: assert property (
    1'b1 |=> preemph_level == $past(preemph_amount))
    else $error("Pre-emphasis amount not applied");
  AST_EDGE_12G: assert property (
    reclock_en && !edge_ovr_en && rate_class == 7'h02 |=> edge_rate == EDGE_W'(`RCC_EDGE_12G))
    else $error("12G edge rate wrong");
  AST_EDGE_SD: assert property (
    reclock_en && !edge_ovr_en && rate_class == 7'h20 |=> edge_rate == EDGE_W'(`RCC_EDGE_SD))
    else $error("SD edge rate wrong");
  AST_EDGE_HOST: assert property (
    !reclock_en || edge_ovr_en |=> edge_rate == $past(edge_ovr_value))
    else $error("Host edge rate not applied");
  AST_POLARITY: assert property (
    1'b1 |=> {pol_line_output_a, pol_line_output_b, pol_host_loopback_output} ==
      $past({invert_line_a, invert_line_b, invert_loopback}))
    else $error("Polarity control not applied");
  AST_LB_DEFAULT: assert property (
    !lb_ovr_amp_en && !lb_ovr_deemph_en |=> lb_amp == `RCC_LB_AMP_RST && lb_deemph == `RCC_LB_DEEMPH_RST)
    else $error("Loop-back default wrong");
  AST_LB_OVR: assert property (
    lb_ovr_amp_en && lb_ovr_deemph_en |=> lb_amp == $past(lb_ovr_amp) && lb_deemph == $past(lb_ovr_deemph))
    else $error("Loop-back override wrong");
  AST_SIGDET_PIN: assert property (
    status_sel == `RCC_STAT_SIGDET && q.sd2 |=> !status_pin_oe)
    else $error("Signal detect not shown on pin");
  AST_LOCK_PIN: assert property (
    status_sel == `RCC_STAT_LOCK && !q.lk2 |=> status_pin_oe)
    else $error("Lock pin low without lock");
  AST_INT_STICKY: assert property (
    status_sel == 2'h2 && q.int_flag && !int_status_read ##1 status_sel == 2'h2 |=> !status_pin_oe)
    else $error("Interrupt flag released early");
  AST_INT_CLEAR: assert property (
    status_sel == `RCC_STAT_INT && int_status_read && !q.ev2 ##1
      status_sel == `RCC_STAT_INT && !q.ev2 |=> status_pin_oe)
    else $error("Interrupt flag not released");
  AST_STRAP_HOLD: assert property (
    straps_ready |=> $stable(q.path_lv) && $stable(q.eq_lv) && $stable(q.amp_lv))
    else $error("Strap level moved after capture");
  AST_RATE_HOLD: assert property (
    !q.lk2 |=> $stable(rate_class))
    else $error("Rate class moved without lock");
  AST_AUTO_HOLD: assert property (
    !q.lk2 |=> $stable(q.pe_auto) && $stable(q.edge_auto))
    else $error("Auto selection moved without lock");
  COV_RATE_12G: cover property (rate_class == 7'h02 && preemph_en);
  COV_BYPASS: cover property (!reclock_en && preemph_en);
  COV_MADI: cover property (rate_class == 7'h40 && !reclock_en);
  COV_EYE_DONE: cover property (eye_done);
  COV_INT_PIN: cover property (status_sel == 2'h2 && !status_pin_oe);
endmodule
`default_nettype wire

//--- include/rcc_consts.svh
// Constants for the reclocker output configuration control
`ifndef RCC_CONSTS_SVH
`define RCC_CONSTS_SVH
`define RCC_LVL_L 2'h0
`define RCC_LVL_R 2'h1
`define RCC_LVL_F 2'h2
`define RCC_LVL_H 2'h3
`define RCC_EQ_FIXED_R 8'h80
`define RCC_EQ_FIXED_L 8'h90
`define RCC_EQ_FIXED_ZERO 8'h00
`define RCC_AMP_NOM 8'h50
`define RCC_AMP_STEP_5 8'h04
`define RCC_AMP_STEP_10 8'h08
`define RCC_LB_AMP_RST 8'h39
`define RCC_LB_DEEMPH_RST 4'h4
`define RCC_EDGE_12G 10'h022
`define RCC_EDGE_6G 10'h024
`define RCC_EDGE_3G 10'h03b
`define RCC_EDGE_1G5 10'h03c
`define RCC_EDGE_SD 10'h226
`define RCC_EYE_STEPS 7'h40
`define RCC_STAT_LOCK 2'h0
`define RCC_STAT_SIGDET 2'h1
`define RCC_STAT_INT 2'h2
`endif

//--- include/rcc_pkg.sv
// Types for the reclocker output configuration control
package rcc_pkg;
  typedef enum logic [6:0] {
    RCC_RATE_NONE = 7'h01,
    RCC_RATE_12G = 7'h02,
    RCC_RATE_6G = 7'h04,
    RCC_RATE_3G = 7'h08,
    RCC_RATE_1G5 = 7'h10,
    RCC_RATE_SD = 7'h20,
    RCC_RATE_MADI = 7'h40
  } rcc_rate_t;
  typedef enum logic [2:0] {
    RCC_EYE_IDLE = 3'h1,
    RCC_EYE_SCAN = 3'h2,
    RCC_EYE_DONE = 3'h4
  } rcc_eye_state_t;
endpackage

//--- verilog/rcc_eye_scan.sv
// Eye monitor capture grid sequencer and opening measurement
`timescale 1ns/1ns
`default_nettype none
`include "rcc_consts.svh"
module rcc_eye_scan
  import rcc_pkg::*;
#(
  parameter int STEPS = 64
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic start,
  input wire logic sample_hit,
  output logic [5:0] phase_idx,
  output logic [5:0] volt_idx,
  output logic busy,
  output logic done,
  output logic [6:0] eye_width,
  output logic [6:0] eye_height
);
  typedef struct packed {
    rcc_eye_state_t st;
    logic [5:0] ph;
    logic [5:0] vo;
    logic [6:0] run_w;
    logic [6:0] best_w;
    logic [6:0] run_h;
    logic [6:0] best_h;
    logic done;
  } rcc_eye_reg_t;
  rcc_eye_reg_t q, next_q;
  logic last_ph, last_vo;
  always_comb begin
    next_q = q;
    next_q.done = 1'b0;
    last_ph = (q.ph == 6'(STEPS - 1));
    last_vo = (q.vo == 6'(STEPS - 1));
    case (q.st)
      RCC_EYE_IDLE, RCC_EYE_DONE: begin
        if (start && enable) begin
          next_q.st = RCC_EYE_SCAN;
          next_q.ph = 6'h00;
          next_q.vo = 6'h00;
          next_q.run_w = 7'h00;
          next_q.best_w = 7'h00;
          next_q.run_h = 7'h00;
          next_q.best_h = 7'h00;
        end
      end
      RCC_EYE_SCAN: begin
        if (!enable) begin
          next_q.st = RCC_EYE_IDLE;
        end else begin
          // Width measured along the centre voltage row, height along the centre phase column
          if (q.vo == 6'(STEPS / 2)) begin
            next_q.run_w = sample_hit ? 7'h00 : q.run_w + 7'h01;
            if (!sample_hit && (q.run_w + 7'h01 > q.best_w)) next_q.best_w = q.run_w + 7'h01;
          end
          if (q.ph == 6'(STEPS / 2)) begin
            next_q.run_h = sample_hit ? 7'h00 : q.run_h + 7'h01;
            if (!sample_hit && (q.run_h + 7'h01 > q.best_h)) next_q.best_h = q.run_h + 7'h01;
          end
          next_q.ph = q.ph + 6'h01;
          if (last_ph) begin
            next_q.vo = q.vo + 6'h01;
            if (last_vo) begin
              next_q.st = RCC_EYE_DONE;
              next_q.done = 1'b1;
            end
          end
        end
      end
      default: next_q.st = RCC_EYE_IDLE;
    endcase
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '{st: RCC_EYE_IDLE, default: '0};
    end else begin
      q <= next_q;
    end
  end
  assign phase_idx = q.ph;
  assign volt_idx = q.vo;
  assign busy = (q.st == RCC_EYE_SCAN);
  assign done = q.done;
  assign eye_width = q.best_w;
  assign eye_height = q.best_h;
  AST_EYE_OFF_STOPS: assert property (@(posedge clk) disable iff (!rst_n)
    busy && !enable |=> !busy) else $error("Eye scan kept running below rate floor");
  AST_EYE_GRID_WRAP: assert property (@(posedge clk) disable iff (!rst_n)
    busy && enable && phase_idx == 6'h3f |=> phase_idx == 6'h00) else $error("Phase step did not wrap");
endmodule
`default_nettype wire

//--- sim/rcc_source_model.sv
// Serial video source and recovery loop front end facing the control block
`timescale 1ns/1ns
`default_nettype none
module rcc_source_model (
  input wire logic clk,
  input wire logic lock_req,
  input wire logic [3:0] code_req,
  input wire logic frac_req,
  input wire logic sig_req,
  input wire logic slow,
  input wire logic [5:0] eye_phase,
  input wire logic [5:0] eye_volt,
  output logic cdr_lock,
  output logic [3:0] cdr_rate_code,
  output logic cdr_frac_rate,
  output logic signal_present,
  output logic eye_sample_hit
);
  logic [4:0] wait_cnt = 5'h00;
  logic [3:0] churn = 4'h0;
  initial begin
    {cdr_lock, cdr_rate_code, cdr_frac_rate, signal_present} = 7'h00;
  end
  always @(negedge clk) begin
    churn <= churn + 4'h1;
    signal_present <= sig_req;
    if (!lock_req) begin
      wait_cnt <= 5'h00;
      cdr_lock <= 1'b0;
      // The code means nothing while unlocked, so it keeps moving
      cdr_rate_code <= churn;
      cdr_frac_rate <= churn[0];
    end else if (wait_cnt < (slow ? 5'h14 : 5'h01)) begin
      wait_cnt <= wait_cnt + 5'h01;
    end else begin
      cdr_lock <= 1'b1;
      cdr_rate_code <= code_req;
      cdr_frac_rate <= frac_req;
    end
  end
  // Open eye of 32 phase steps by 24 voltage steps in mid grid
  assign eye_sample_hit = (eye_phase < 6'h10) || (eye_phase > 6'h2f) || (eye_volt < 6'h14) || (eye_volt > 6'h2b);
endmodule
`default_nettype wire

//--- sim/rcc_ctrl_tb.sv
// Self-checking bench for the reclocker output configuration control
`timescale 1ns/1ns
`default_nettype none
`include "rcc_consts.svh"
module rcc_ctrl_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] path_strap, equalizer_strap, line_amplitude_strap, amp_ovr_level, status_sel;
  logic cdr_lock, cdr_frac_rate, signal_present, eye_sample_hit;
  logic [3:0] cdr_rate_code, preemph_amount, lb_ovr_deemph, preemph_level, lb_deemph, code_req;
  logic path_ovr_en, path_ovr_reclock, amp_ovr_en, preemph_auto_dis, preemph_force, edge_ovr_en;
  logic invert_line_a, invert_line_b, invert_loopback, lb_ovr_amp_en, lb_ovr_deemph_en;
  logic int_event, int_status_read, eye_start, lock_req, frac_req, sig_req, slow;
  logic [7:0] amp_nominal, lb_ovr_amp, eq_fixed_boost, line_amp, lb_amp;
  logic [9:0] edge_ovr_value, edge_rate;
  logic reclock_en, eq_enable, fixed_eq_mode, adaptive_eq_mode, preemph_en, pol_line_output_a;
  logic pol_line_output_b, pol_host_loopback_output, eye_monitor_en, eye_busy, eye_done;
  logic status_pin_out, status_pin_oe;
  logic [6:0] rate_class, horizontal_eye_width, vertical_eye_height;
  logic [5:0] eye_phase, eye_volt;
  integer seed = 32'hed47;
  int err_total = 0;
  int tests_run = 0;
  int busy_n;
  int hits_n;
  int wait_n;
  // Pull-up on the open-drain status line
  wire status_line = status_pin_oe ? 1'b1 : status_pin_out;

  rcc_ctrl u_rcc_ctrl (
    .clk, .rst_n, .path_strap, .equalizer_strap, .line_amplitude_strap, .cdr_lock, .cdr_rate_code,
    .cdr_frac_rate, .signal_present, .eye_sample_hit, .path_ovr_en, .path_ovr_reclock, .amp_ovr_en,
    .amp_ovr_level, .amp_nominal, .preemph_auto_dis, .preemph_force, .preemph_amount, .edge_ovr_en,
    .edge_ovr_value, .invert_line_a, .invert_line_b, .invert_loopback, .lb_ovr_amp_en, .lb_ovr_amp,
    .lb_ovr_deemph_en, .lb_ovr_deemph, .status_sel, .int_event, .int_status_read, .eye_start,
    .reclock_en, .eq_enable, .fixed_eq_mode, .adaptive_eq_mode, .eq_fixed_boost, .line_amp, .preemph_en,
    .preemph_level, .edge_rate, .pol_line_output_a, .pol_line_output_b, .pol_host_loopback_output,
    .lb_amp, .lb_deemph, .rate_class, .eye_monitor_en, .eye_phase, .eye_volt, .eye_busy, .eye_done,
    .horizontal_eye_width, .vertical_eye_height, .status_pin_out, .status_pin_oe
  );
  rcc_source_model u_rcc_source_model (
    .clk, .lock_req, .code_req, .frac_req, .sig_req, .slow, .eye_phase, .eye_volt,
    .cdr_lock, .cdr_rate_code, .cdr_frac_rate, .signal_present, .eye_sample_hit
  );

  always #5 clk = ~clk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic do_reset(input logic [1:0] lvl);
    rst_n = 1'b0;
    {path_strap, equalizer_strap, line_amplitude_strap} = {lvl, lvl, lvl};
    cyc(10);
    rst_n = 1'b1;
    cyc(8);
  endtask
  // Slow lock takes 20 cycles, then sync and decode need a few more
  task automatic lock_to(input logic [3:0] code);
    lock_req = 1'b0;
    cyc(4);
    code_req = code;
    frac_req = 1'($random(seed));
    slow = 1'($random(seed));
    lock_req = 1'b1;
    cyc(32);
  endtask
  function automatic logic [9:0] exp_edge(input logic [3:0] c);
    case (c)
      4'h1: return `RCC_EDGE_12G;
      4'h2: return `RCC_EDGE_6G;
      4'h3: return `RCC_EDGE_3G;
      4'h4: return `RCC_EDGE_1G5;
      default: return `RCC_EDGE_SD;
    endcase
  endfunction
  function automatic logic [7:0] exp_amp(input logic [1:0] l, input logic [7:0] nom);
    case (l)
      `RCC_LVL_H: return nom + `RCC_AMP_STEP_5;
      `RCC_LVL_R: return nom + `RCC_AMP_STEP_10;
      `RCC_LVL_L: return nom - `RCC_AMP_STEP_5;
      default: return nom;
    endcase
  endfunction

  initial begin
    {path_strap, equalizer_strap, line_amplitude_strap, amp_ovr_level, status_sel} = 10'h000;
    {path_ovr_en, path_ovr_reclock, amp_ovr_en, preemph_auto_dis, preemph_force, edge_ovr_en} = 6'h00;
    {invert_line_a, invert_line_b, invert_loopback, lb_ovr_amp_en, lb_ovr_deemph_en} = 5'h00;
    {int_event, int_status_read, eye_start, lock_req, frac_req, sig_req, slow} = 7'h00;
    {preemph_amount, lb_ovr_deemph, lb_ovr_amp, edge_ovr_value, code_req} = 30'h0;
    amp_nominal = `RCC_AMP_NOM;
    cyc(10);
    check("rst_line_amp", line_amp, `RCC_AMP_NOM);
    check("rst_lb_amp", lb_amp, `RCC_LB_AMP_RST);
    check("rst_lb_deemph", lb_deemph, `RCC_LB_DEEMPH_RST);
    check("rst_rate_class", rate_class, 7'h01);
    check("rst_status", status_line, 1'b1);
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1:0]);
      sig_req = 1'b1;
      amp_nominal = 8'h40 + (8'($random(seed)) & 8'h1f);
      lock_to(4'h3);
      check("reclock_en", reclock_en, i >= 2);
      check("eq_enable", eq_enable, 1'b1);
      check("line_amp", line_amp, exp_amp(i[1:0], amp_nominal));
      check("lock_status", status_line, 1'b0);
      if (i < 2) begin
        check("fixed_eq_mode", fixed_eq_mode, 1'b1);
        check("eq_fixed_boost", eq_fixed_boost, i ? `RCC_EQ_FIXED_R : `RCC_EQ_FIXED_L);
      end
    end
    path_strap = `RCC_LVL_L;
    cyc(8);
    check("strap_held", reclock_en, 1'b1);
    edge_ovr_value = 10'($random(seed));
    preemph_amount = 4'($random(seed));
    for (int c = 1; c <= 7; c++) begin
      lock_to(c == 7 ? 4'h1 : c[3:0]);
      check("rate_class", rate_class, 7'h01 << (c == 7 ? 1 : c));
      check("reclock_en", reclock_en, c != 6);
      check("preemph_en", preemph_en, c <= 2 || c == 7);
      check("preemph_level", preemph_level, preemph_amount);
      check("edge_rate", edge_rate, c == 6 ? edge_ovr_value : exp_edge(c == 7 ? 4'h1 : c[3:0]));
      check("eye_monitor_en", eye_monitor_en, c <= 3 || c == 7);
    end
    lock_req = 1'b0;
    cyc(20);
    check("held_class", rate_class, 7'h02);
    check("held_preemph", preemph_en, 1'b1);
    check("held_edge", edge_rate, `RCC_EDGE_12G);
    check("unlock_status", status_line, 1'b1);
    path_ovr_en = 1'b1;
    amp_ovr_en = 1'b1;
    amp_ovr_level = 2'($random(seed));
    edge_ovr_en = 1'b1;
    {invert_line_a, invert_line_b, invert_loopback} = 3'($random(seed));
    lb_ovr_amp_en = 1'b1;
    lb_ovr_amp = 8'($random(seed));
    preemph_auto_dis = 1'b1;
    cyc(8);
    check("ovr_bypass", reclock_en, 1'b0);
    check("ovr_amp", line_amp, exp_amp(amp_ovr_level, amp_nominal));
    check("ovr_edge", edge_rate, edge_ovr_value);
    check("auto_off", preemph_en, 1'b0);
    check("pol", {pol_line_output_a, pol_line_output_b, pol_host_loopback_output},
          {invert_line_a, invert_line_b, invert_loopback});
    check("lb_amp", lb_amp, lb_ovr_amp);
    check("lb_deemph_kept", lb_deemph, `RCC_LB_DEEMPH_RST);
    preemph_force = 1'b1;
    lb_ovr_deemph_en = 1'b1;
    lb_ovr_deemph = 4'($random(seed));
    path_ovr_reclock = 1'b1;
    cyc(8);
    check("forced_pe", preemph_en, 1'b1);
    check("lb_deemph", lb_deemph, lb_ovr_deemph);
    check("ovr_reclock", reclock_en, 1'b1);
    status_sel = `RCC_STAT_SIGDET;
    sig_req = 1'b0;
    cyc(8);
    check("sigdet_off", status_line, 1'b1);
    sig_req = 1'b1;
    cyc(8);
    check("sigdet_on", status_line, 1'b0);
    status_sel = `RCC_STAT_INT;
    cyc(8);
    check("int_idle", status_line, 1'b1);
    int_event = 1'b1;
    cyc(1);
    int_event = 1'b0;
    cyc(16);
    check("int_sticky", status_line, 1'b0);
    int_status_read = 1'b1;
    cyc(1);
    int_status_read = 1'b0;
    cyc(8);
    check("int_clear", status_line, 1'b1);
    lock_to(4'h1);
    eye_start = 1'b1;
    cyc(1);
    eye_start = 1'b0;
    // The first grid point is already on show here, so it is counted before the first step
    busy_n = int'(eye_busy === 1'b1);
    hits_n = int'(eye_busy === 1'b1 && eye_sample_hit === 1'b1);
    wait_n = 0;
    while (eye_done !== 1'b1 && wait_n < 5000) begin
      cyc(1);
      busy_n += int'(eye_busy === 1'b1);
      hits_n += int'(eye_busy === 1'b1 && eye_sample_hit === 1'b1);
      wait_n++;
    end
    check("scan_done", eye_done, 1'b1);
    check("scan_points", busy_n, 4096);
    // One observation per point, so the hit total is the closed part of the grid
    check("scan_hits", hits_n, 4096 - 32 * 24);
    check("eye_width", horizontal_eye_width, 7'h20);
    check("eye_height", vertical_eye_height, 7'h18);
    eye_start = 1'b1;
    cyc(1);
    eye_start = 1'b0;
    cyc(10);
    check("eye_running", eye_busy, 1'b1);
    lock_req = 1'b0;
    cyc(8);
    check("eye_abort", eye_busy, 1'b0);
    lock_to(4'h5);
    eye_start = 1'b1;
    cyc(1);
    eye_start = 1'b0;
    cyc(6);
    check("eye_refused", eye_busy, 1'b0);
    final_report();
  end

  // Whole run needs well under 20000 cycles
  initial begin
    #500000;
    err_total++;
    final_report();
  end
endmodule
`default_nettype wire
